// [design/epci_top.sv]
// External and pin-change interrupt unit with an APB register slave.
// Assumes pins are asynchronous, I_GIE and acks come from this same clock, and
// I_IO_CLK_EN marks cycles in which the gated I/O clock would be running.
//
// Behaviour
// - Pins driven as outputs still raise interrupts.
// - Masked toggle on lines 7..0 raises group lo.
// - Masked toggle on lines 12..8 raises group hi.
// - Pin-change detection needs no I/O clock.
// - Lines 0..3 sense low, any, fall, rise.
// - Lines 4..7 sense low, change, fall, rise.
// - Lines 4..7 edges sampled on I/O clock only.
// - Levels and lines 0..3 edges need no I/O clock.
// - Low level requests while pin stays low.
// - Level wake fires even if level vanishes.
// - Line request needs enable and global enable.
// - Edge sets flag; vector entry clears it.
// - Writing one clears flag; zero keeps it.
// - Flag held clear in low-level mode.
// - Sleep with lines 0..3 disabled forces input low.
// - Group request needs group and global enable.
// - Toggle sets group flag; vector or one clears.
// - Each mask bit includes its own pin.
`timescale 1ns/1ps
`default_nettype none
module epci_top (
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   input wire epci_pkg::epci_apb_req_t I_APB_REQ,
   input wire logic I_IO_CLK_EN,
   input wire logic I_SLEEP,
   input wire logic I_GIE,
   input wire logic [7:0] I_EXT_PIN,
   input wire logic [12:0] I_PC_PIN,
   input wire logic [7:0] I_EXT_ACK,
   input wire logic [1:0] I_PC_ACK,
   output epci_pkg::epci_apb_rsp_t O_APB_RSP,
   output logic [7:0] O_EXT_IRQ,
   output logic [1:0] O_PC_IRQ,
   output logic O_WAKE
);
   //////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [20:0] pin_sync; // Synchronised dedicated and pin-change levels
   logic [7:0] ext_lvl; // Line level after the input buffer gate
   logic [7:0] ext_prev_r; // Last level seen by each edge detector
   logic [7:0] ext_upd; // Detector may look at the line this cycle
   logic [7:0] ext_evt; // Edge or change selected by the sense bits
   logic [7:0] lvl_mode; // Line set to low-level sensing
   logic [15:0] sense; // Both sense registers side by side
   logic [12:0] pc_prev_r; // Previous pin-change levels
   logic [12:0] pc_tog; // Masked toggles
   logic [1:0] pc_evt; // Group events
   logic [7:0] flag_r; // ext_irq_flags
   logic [7:0] en_r; // ext_irq_enable
   logic [7:0] sense_lo_r; // ext_sense_ctrl_low
   logic [7:0] sense_hi_r; // ext_sense_ctrl_high
   logic [1:0] pc_en_r; // pin_change_ctrl
   logic [1:0] pc_flag_r; // pin_change_flag_reg
   logic [7:0] pc_mask_lo_r; // pin_change_mask_lo
   logic [4:0] pc_mask_hi_r; // pin_change_mask_hi
   logic [9:0] idx; // Word index of the bus address
   logic acc_done; // Access phase completes on this edge
   logic wr_en; // Write takes effect on this edge
   logic [7:0] wbyte; // Low byte of the write data
   logic [7:0] ext_clr; // Clear requests for line flags
   logic [1:0] pc_clr; // Clear requests for group flags
   logic hit; // Address decodes to a register
   logic [31:0] rd_mux; // Read data before the output flop
   logic [7:0] ext_irq_nxt; // Line requests before the output flop
   logic [1:0] pc_irq_nxt; // Group requests before the output flop
   logic wake_nxt; // Wake before the output flop

   //////////////////////////////////////////////////////////////////////////
   // Pins cross into the clock domain before anything reads them
   epci_sync #(
      .W(21)
   ) u_sync (
      .i_clk(I_MCLK),
      .i_rst(I_SYS_RST),
      .i_async({I_PC_PIN, I_EXT_PIN}),
      .o_sync(pin_sync)
   );

   assign sense = {sense_hi_r, sense_lo_r};

   //////////////////////////////////////////////////////////////////////////
   // Per-line input gate, update enable and sense decode
   for (genvar g = 0; g < epci_pkg::NUM_EXT; g++) begin : g_line
      localparam bit ASYNC = (g < epci_pkg::NUM_ASYNC);
      epci_pkg::epci_sense_t mode; // Sense of this line
      assign mode = epci_pkg::epci_sense_t'(sense[2*g+1:2*g]);
      // Sleeping with the line disabled turns its buffer off, lines 0..3 only
      assign ext_lvl[g] = (ASYNC && I_SLEEP && !en_r[g]) ?
                          1'b0 : pin_sync[g];
      // Low lines see every cycle, high lines only with I/O clock
      assign ext_upd[g] = ASYNC ? 1'b1 : I_IO_CLK_EN;
      assign lvl_mode[g] = (mode == epci_pkg::SENSE_LOW);
      // Edge selection between two successive looks
      always_comb begin
         unique case (mode)
            epci_pkg::SENSE_LOW: ext_evt[g] = 1'b0;
            epci_pkg::SENSE_ANY:
               ext_evt[g] = ext_upd[g] && (ext_lvl[g] != ext_prev_r[g]);
            epci_pkg::SENSE_FALL:
               ext_evt[g] = ext_upd[g] && !ext_lvl[g] && ext_prev_r[g];
            epci_pkg::SENSE_RISE:
               ext_evt[g] = ext_upd[g] && ext_lvl[g] && !ext_prev_r[g];
         endcase
      end
   end : g_line

   //////////////////////////////////////////////////////////////////////////
   // Edge detector history; high lines hold while the I/O clock is off
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ext_prev_r <= epci_pkg::RST_BYTE;
      end else begin
         // Pin level counts whatever drives it, output or not
         ext_prev_r <= (ext_lvl & ext_upd) | (ext_prev_r & ~ext_upd);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pin-change history runs every cycle, I/O clock or not
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pc_prev_r <= {epci_pkg::RST_MASK_HI, epci_pkg::RST_BYTE};
      end else begin
         pc_prev_r <= pin_sync[20:8];
      end
   end

   // Mask bits pick the lines that count
   assign pc_tog = (pin_sync[20:8] ^ pc_prev_r) &
                   {pc_mask_hi_r, pc_mask_lo_r};
   assign pc_evt[0] = |pc_tog[7:0];
   assign pc_evt[1] = |pc_tog[12:8];

   //////////////////////////////////////////////////////////////////////////
   // Bus decode; one wait state, writes land on the completing edge
   assign idx = I_APB_REQ.paddr[11:2];
   assign acc_done = I_APB_REQ.psel && I_APB_REQ.penable && O_APB_RSP.pready;
   assign wr_en = acc_done && I_APB_REQ.pwrite;
   assign wbyte = I_APB_REQ.pwdata[7:0];
   assign hit = (idx == epci_pkg::IDX_EXT_FLAGS) ||
                (idx == epci_pkg::IDX_EXT_ENABLE) ||
                (idx == epci_pkg::IDX_SENSE_LOW) ||
                (idx == epci_pkg::IDX_SENSE_HIGH) ||
                (idx == epci_pkg::IDX_PC_CTRL) ||
                (idx == epci_pkg::IDX_PC_FLAGS) ||
                (idx == epci_pkg::IDX_PC_MASK_LO) ||
                (idx == epci_pkg::IDX_PC_MASK_HI);

   //////////////////////////////////////////////////////////////////////////
   // Read mux; unused bits read as zero
   always_comb begin
      rd_mux = epci_pkg::RD_NONE;
      if (idx == epci_pkg::IDX_EXT_FLAGS) begin
         rd_mux[7:0] = flag_r;
      end else if (idx == epci_pkg::IDX_EXT_ENABLE) begin
         rd_mux[7:0] = en_r;
      end else if (idx == epci_pkg::IDX_SENSE_LOW) begin
         rd_mux[7:0] = sense_lo_r;
      end else if (idx == epci_pkg::IDX_SENSE_HIGH) begin
         rd_mux[7:0] = sense_hi_r;
      end else if (idx == epci_pkg::IDX_PC_CTRL) begin
         rd_mux[1:0] = pc_en_r;
      end else if (idx == epci_pkg::IDX_PC_FLAGS) begin
         rd_mux[1:0] = pc_flag_r;
      end else if (idx == epci_pkg::IDX_PC_MASK_LO) begin
         rd_mux[7:0] = pc_mask_lo_r;
      end else if (idx == epci_pkg::IDX_PC_MASK_HI) begin
         rd_mux[4:0] = pc_mask_hi_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Bus answer: ready one cycle into access, error on unmapped words
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_APB_RSP <= '0;
      end else if (I_APB_REQ.psel && I_APB_REQ.penable &&
                   !O_APB_RSP.pready) begin
         O_APB_RSP.pready <= 1'b1;
         O_APB_RSP.pslverr <= !hit;
         O_APB_RSP.prdata <= rd_mux;
      end else begin
         O_APB_RSP <= '0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Plain control registers; sense changes take effect at once, so
   // software should disable the line first
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         en_r <= epci_pkg::RST_BYTE;
         sense_lo_r <= epci_pkg::RST_BYTE;
         sense_hi_r <= epci_pkg::RST_BYTE;
         pc_en_r <= epci_pkg::RST_PAIR;
         pc_mask_lo_r <= epci_pkg::RST_BYTE;
         pc_mask_hi_r <= epci_pkg::RST_MASK_HI;
      end else if (wr_en) begin
         if (idx == epci_pkg::IDX_EXT_ENABLE) begin
            en_r <= wbyte;
         end
         if (idx == epci_pkg::IDX_SENSE_LOW) begin
            sense_lo_r <= wbyte;
         end
         if (idx == epci_pkg::IDX_SENSE_HIGH) begin
            sense_hi_r <= wbyte;
         end
         if (idx == epci_pkg::IDX_PC_CTRL) begin
            pc_en_r <= wbyte[1:0];
         end
         if (idx == epci_pkg::IDX_PC_MASK_LO) begin
            pc_mask_lo_r <= wbyte;
         end
         if (idx == epci_pkg::IDX_PC_MASK_HI) begin
            pc_mask_hi_r <= wbyte[4:0];
         end
      end
   end

   // Write-one-clear and vector acknowledge share one clear path
   assign ext_clr = I_EXT_ACK |
      ((wr_en && idx == epci_pkg::IDX_EXT_FLAGS) ? wbyte : 8'h00);
   assign pc_clr = I_PC_ACK |
      ((wr_en && idx == epci_pkg::IDX_PC_FLAGS) ? wbyte[1:0] : 2'h0);

   //////////////////////////////////////////////////////////////////////////
   // Line flags: level mode holds clear, then event beats clear
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         flag_r <= epci_pkg::RST_BYTE;
      end else begin
         flag_r <= ~lvl_mode & (ext_evt | (flag_r & ~ext_clr));
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Group flags: a toggle in the clear cycle is kept
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pc_flag_r <= epci_pkg::RST_PAIR;
      end else begin
         pc_flag_r <= pc_evt | (pc_flag_r & ~pc_clr);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Requests and wake, registered so outputs come from flops
   always_comb begin
      // Level lines request straight from the pin while it is low
      ext_irq_nxt = {8{I_GIE}} & en_r &
                    ((lvl_mode & ~ext_lvl) | flag_r);
      pc_irq_nxt = {2{I_GIE}} & pc_en_r & pc_flag_r;
      // Wake ignores the global enable; a level gone before start-up
      // ends still wakes but leaves no request behind
      wake_nxt = |(en_r & lvl_mode & ~ext_lvl) | |(en_r & flag_r) |
                 |(pc_en_r & pc_flag_r);
   end

   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_EXT_IRQ <= epci_pkg::RST_BYTE;
         O_PC_IRQ <= epci_pkg::RST_PAIR;
         O_WAKE <= 1'b0;
      end else begin
         O_EXT_IRQ <= ext_irq_nxt;
         O_PC_IRQ <= pc_irq_nxt;
         O_WAKE <= wake_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (I_SYS_RST);

   sequence s_setup;
      I_APB_REQ.psel && !I_APB_REQ.penable;
   endsequence
   sequence s_access;
      I_APB_REQ.psel && I_APB_REQ.penable;
   endsequence

   property p_apb_ready;
      s_setup ##1 s_access |-> ##1 O_APB_RSP.pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("APB ready not one cycle into access");

   property p_ext_gate;
      (|O_EXT_IRQ) |-> $past(I_GIE);
   endproperty
   a_ext_gate: assert property (p_ext_gate)
      else $error("Line request without global enable");

   property p_pc_gate;
      (|(O_PC_IRQ & ~$past(pc_en_r))) == 1'b0;
   endproperty
   a_pc_gate: assert property (p_pc_gate)
      else $error("Group request without group enable");

   property p_level_clear;
      1 |=> ((flag_r & $past(lvl_mode)) == 8'h00);
   endproperty
   a_level_clear: assert property (p_level_clear)
      else $error("Flag set in low-level mode");

   property p_evt_sets;
      (|(ext_evt & ~lvl_mode)) |=>
         ((flag_r & $past(ext_evt)) == $past(ext_evt));
   endproperty
   a_evt_sets: assert property (p_evt_sets)
      else $error("Edge did not set its flag");

   property p_clear_flag;
      (|ext_clr) && !(|ext_evt) |=> ((flag_r & $past(ext_clr)) == 8'h00);
   endproperty
   a_clear_flag: assert property (p_clear_flag)
      else $error("Flag not cleared by write or ack");

   property p_level_req;
      I_GIE && (|(en_r & lvl_mode & ~ext_lvl)) |=>
         ((O_EXT_IRQ & $past(en_r & lvl_mode & ~ext_lvl)) ==
          $past(en_r & lvl_mode & ~ext_lvl));
   endproperty
   a_level_req: assert property (p_level_req)
      else $error("Low level did not request");

   property p_group_lo;
      (|pc_tog[7:0]) |=> pc_flag_r[0] ##1 (pc_flag_r[0] || $past(pc_clr[0]));
   endproperty
   a_group_lo: assert property (p_group_lo)
      else $error("Group lo toggle lost");

   property p_group_hi;
      (|pc_tog[12:8]) && !I_IO_CLK_EN |=> pc_flag_r[1];
   endproperty
   a_group_hi: assert property (p_group_hi)
      else $error("Group hi toggle lost without I/O clock");

   property p_io_hold;
      !I_IO_CLK_EN |=> ((flag_r & ~$past(flag_r) & 8'hF0) == 8'h00);
   endproperty
   a_io_hold: assert property (p_io_hold)
      else $error("High line edge seen without I/O clock");
endmodule : epci_top
`default_nettype wire

// [design/epci_pkg.sv]
// Constants and carrier types of the external and pin-change interrupt unit.
// Assumes a single clock; register indices map to byte address index*4.
package epci_pkg;
   //////////////////////////////////////////////////////////////////////////
   // Register indices; the bus byte address is four times the index
   localparam logic [9:0] IDX_EXT_FLAGS = 10'h03C; // Line flags, W1C
   localparam logic [9:0] IDX_EXT_ENABLE = 10'h03D; // Line enables
   localparam logic [9:0] IDX_SENSE_LOW = 10'h069; // Sense of lines 3..0
   localparam logic [9:0] IDX_SENSE_HIGH = 10'h06A; // Sense of lines 7..4
   localparam logic [9:0] IDX_PC_CTRL = 10'h068; // Group enables
   localparam logic [9:0] IDX_PC_FLAGS = 10'h03B; // Group flags, W1C
   localparam logic [9:0] IDX_PC_MASK_LO = 10'h06B; // Mask of lines 7..0
   localparam logic [9:0] IDX_PC_MASK_HI = 10'h06C; // Mask of lines 12..8
   //////////////////////////////////////////////////////////////////////////
   // Widths and reset values
   localparam int NUM_EXT = 8; // Dedicated lines
   localparam int NUM_PC = 13; // Pin-change lines
   localparam int NUM_ASYNC = 4; // Dedicated lines detected without I/O clock
   localparam logic [7:0] RST_BYTE = 8'h00; // Every register resets to zero
   localparam logic [1:0] RST_PAIR = 2'h0; // Group enables and flags
   localparam logic [4:0] RST_MASK_HI = 5'h00; // Upper mask
   localparam logic [31:0] RD_NONE = 32'h0000_0000; // Unmapped read value
   //////////////////////////////////////////////////////////////////////////
   // Sense selection of one dedicated line
   typedef enum logic [1:0] {
      SENSE_LOW = 2'b00, // Low level requests
      SENSE_ANY = 2'b01, // Any edge or change
      SENSE_FALL = 2'b10, // Falling edge
      SENSE_RISE = 2'b11 // Rising edge
   } epci_sense_t;
   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } epci_apb_req_t;
   // APB answer to the master
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } epci_apb_rsp_t;
endpackage : epci_pkg

// [design/epci_sync.sv]
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to the clock; no logic reads stage one.
`timescale 1ns/1ps
`default_nettype none
module epci_sync #(
   parameter int W = 8 // Bundle width
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_r; // Stage one, read by stage two only
   //////////////////////////////////////////////////////////////////////////
   // Both stages reset low, so a pin held high shows one rising transition after reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= '0;
         o_sync <= '0;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule : epci_sync
`default_nettype wire

// [verif/epci_cpu_model.sv]
// Behavioural processor side of the interrupt unit: takes one vector at a
// time. Assumes requests are registered levels on the block's own clock.
`timescale 1ns/1ps
`default_nettype none
module epci_cpu_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ack_en,
   input wire logic [7:0] i_ext_irq,
   input wire logic [1:0] i_pc_irq,
   output logic [7:0] o_ext_ack,
   output logic [1:0] o_pc_ack
);
   ////////////////////////////////////////////////////////////////////////
   logic [2:0] hold_r; // Pause before the next vector may be taken
   logic [9:0] pend; // Pending requests, groups on top
   assign pend = {i_pc_irq, i_ext_irq};
   // Acknowledge the lowest pending source for one cycle, then pause
   // so that the cleared flag has time to drop its request
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         hold_r <= 3'h0;
         {o_pc_ack, o_ext_ack} <= 10'h000;
      end else if (i_ack_en && hold_r == 3'h0 && pend != 10'h000) begin
         {o_pc_ack, o_ext_ack} <= pend & (~pend + 10'h001);
         hold_r <= 3'h4;
      end else begin
         {o_pc_ack, o_ext_ack} <= 10'h000;
         if (hold_r != 3'h0) begin
            hold_r <= hold_r - 3'h1;
         end
      end
   end
endmodule : epci_cpu_model
`default_nettype wire

// [verif/test_epci_top.sv]
// Self-checking bench of the interrupt unit: APB tasks and pin sequences.
// Assumes the processor model in epci_cpu_model and one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_epci_top;
   ////////////////////////////////////////////////////////////////////////
   logic clk = 1'b0; // System clock
   logic rst = 1'b1; // Async reset, active high
   epci_pkg::epci_apb_req_t req = '0; // Bus request
   epci_pkg::epci_apb_rsp_t rsp; // Bus answer
   logic io_en = 1'b1; // I/O clock running
   logic sleep = 1'b0; // Part asleep
   logic gie = 1'b0; // Global enable
   logic ack_en = 1'b0; // Processor model may take vectors
   logic [7:0] ext_pin = 8'hFF; // Dedicated pins, idle high
   logic [12:0] pc_pin = 13'h0000; // Pin-change pins
   logic [7:0] ext_ack; // From processor model
   logic [1:0] pc_ack;
   logic [7:0] ext_irq;
   logic [1:0] pc_irq;
   logic wake;
   logic [31:0] rd_data; // Last read word
   logic rd_err; // Last error flag
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0; // Timeout counter
   localparam logic [9:0] IDX_TAB [8] = '{epci_pkg::IDX_EXT_FLAGS,
      epci_pkg::IDX_EXT_ENABLE, epci_pkg::IDX_SENSE_LOW,
      epci_pkg::IDX_SENSE_HIGH, epci_pkg::IDX_PC_CTRL,
      epci_pkg::IDX_PC_FLAGS, epci_pkg::IDX_PC_MASK_LO,
      epci_pkg::IDX_PC_MASK_HI};
   ////////////////////////////////////////////////////////////////////////
   // Clock of 40 ns
   always #20 clk = ~clk;
   epci_top dut (.I_MCLK(clk), .I_SYS_RST(rst), .I_APB_REQ(req),
      .I_IO_CLK_EN(io_en), .I_SLEEP(sleep), .I_GIE(gie),
      .I_EXT_PIN(ext_pin), .I_PC_PIN(pc_pin), .I_EXT_ACK(ext_ack),
      .I_PC_ACK(pc_ack), .O_APB_RSP(rsp), .O_EXT_IRQ(ext_irq),
      .O_PC_IRQ(pc_irq), .O_WAKE(wake));
   epci_cpu_model cpu (.i_clk(clk), .i_rst(rst), .i_ack_en(ack_en),
      .i_ext_irq(ext_irq), .i_pc_irq(pc_irq), .o_ext_ack(ext_ack),
      .o_pc_ack(pc_ack));
   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   // Compare seen against expected
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
            exp);
      end
   endtask : check
   // Hang guard; the whole sequence needs under 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // One APB transfer; holds the request until pready is sampled high
   task apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      @(posedge clk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= {idx, 2'b00};
      req.pwdata <= {24'h000000, wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      rd_data = rsp.prdata;
      rd_err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task wr(input logic [9:0] idx, input logic [7:0] wd);
      apb(1'b1, idx, wd);
   endtask : wr
   task rd_chk(input logic [9:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      check(rd_data, {24'h000000, exp});
   endtask : rd_chk
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // Drive all pins as the port would, then let detection settle
   task pins(input logic [7:0] e, input logic [12:0] p);
      @(posedge clk);
      ext_pin <= e;
      pc_pin <= p;
      cyc(6);
   endtask : pins
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      cyc(12);
      rst <= 1'b0;
      // Reset values, unmapped word, read back
      for (int i = 0; i < 8; i++) begin
         rd_chk(IDX_TAB[i], epci_pkg::RST_BYTE);
      end
      apb(1'b0, 10'h100, 8'h00);
      check(rd_data, epci_pkg::RD_NONE);
      check({31'h0, rd_err}, 32'h1);
      wr(epci_pkg::IDX_EXT_ENABLE, 8'hA5);
      rd_chk(epci_pkg::IDX_EXT_ENABLE, 8'hA5);
      wr(epci_pkg::IDX_EXT_ENABLE, 8'h00);
      // Line 0 edge modes with the I/O clock stopped
      @(posedge clk);
      io_en <= 1'b0;
      for (int m = 1; m < 4; m++) begin
         wr(epci_pkg::IDX_SENSE_LOW, {6'h00, 2'(m)});
         wr(epci_pkg::IDX_EXT_FLAGS, 8'hFF);
         pins(8'hFE, 13'h0000);
         rd_chk(epci_pkg::IDX_EXT_FLAGS, {7'h00, m != 3});
         wr(epci_pkg::IDX_EXT_FLAGS, 8'hFF);
         pins(8'hFF, 13'h0000);
         rd_chk(epci_pkg::IDX_EXT_FLAGS, {7'h00, m != 2});
      end
      // Flag left set by the last rising edge
      wr(epci_pkg::IDX_EXT_FLAGS, 8'h00);
      rd_chk(epci_pkg::IDX_EXT_FLAGS, 8'h01);
      wr(epci_pkg::IDX_EXT_FLAGS, 8'h01);
      rd_chk(epci_pkg::IDX_EXT_FLAGS, 8'h00);
      // Falling edge request, global gate, vector acknowledge
      wr(epci_pkg::IDX_SENSE_LOW, 8'h02);
      wr(epci_pkg::IDX_EXT_FLAGS, 8'hFF);
      wr(epci_pkg::IDX_EXT_ENABLE, 8'h01);
      pins(8'hFE, 13'h0000);
      check({24'h0, ext_irq}, 32'h0);
      gie <= 1'b1;
      cyc(3);
      check({24'h0, ext_irq}, 32'h1);
      ack_en <= 1'b1;
      cyc(10);
      rd_chk(epci_pkg::IDX_EXT_FLAGS, 8'h00);
      check({24'h0, ext_irq}, 32'h0);
      ack_en <= 1'b0;
      wr(epci_pkg::IDX_EXT_ENABLE, 8'h00);
      pins(8'hFF, 13'h0000);
      // Low level on lines 2 and 6, no I/O clock, held long
      wr(epci_pkg::IDX_SENSE_LOW, 8'h00);
      wr(epci_pkg::IDX_EXT_ENABLE, 8'h44);
      pins(8'hBB, 13'h0000);
      check({24'h0, ext_irq}, 32'h44);
      check({31'h0, wake}, 32'h1);
      cyc(20);
      check({24'h0, ext_irq}, 32'h44);
      rd_chk(epci_pkg::IDX_EXT_FLAGS, 8'h00);
      pins(8'hFF, 13'h0000);
      check({24'h0, ext_irq}, 32'h0);
      check({31'h0, wake}, 32'h0);
      wr(epci_pkg::IDX_EXT_ENABLE, 8'h00);
      // Line 4 change seen only when the I/O clock samples it
      wr(epci_pkg::IDX_SENSE_HIGH, 8'h01);
      wr(epci_pkg::IDX_EXT_FLAGS, 8'hFF);
      pins(8'hEF, 13'h0000);
      rd_chk(epci_pkg::IDX_EXT_FLAGS, 8'h00);
      io_en <= 1'b1;
      cyc(6);
      rd_chk(epci_pkg::IDX_EXT_FLAGS, 8'h10);
      // Line 4 rising, then falling, with the I/O clock running
      wr(epci_pkg::IDX_SENSE_HIGH, 8'h03);
      wr(epci_pkg::IDX_EXT_FLAGS, 8'hFF);
      pins(8'hFF, 13'h0000);
      rd_chk(epci_pkg::IDX_EXT_FLAGS, 8'h10);
      wr(epci_pkg::IDX_SENSE_HIGH, 8'h02);
      wr(epci_pkg::IDX_EXT_FLAGS, 8'hFF);
      pins(8'hEF, 13'h0000);
      rd_chk(epci_pkg::IDX_EXT_FLAGS, 8'h10);
      wr(epci_pkg::IDX_SENSE_HIGH, 8'h00);
      pins(8'hFF, 13'h0000);
      // Sleep with line 1 disabled turns its buffer off
      wr(epci_pkg::IDX_SENSE_LOW, 8'h04);
      wr(epci_pkg::IDX_EXT_FLAGS, 8'hFF);
      sleep <= 1'b1;
      cyc(6);
      rd_chk(epci_pkg::IDX_EXT_FLAGS, 8'h02);
      sleep <= 1'b0;
      io_en <= 1'b0;
      // Pin-change groups, masks and their flags
      wr(epci_pkg::IDX_PC_MASK_LO, 8'h08);
      wr(epci_pkg::IDX_PC_CTRL, 8'h01);
      pins(8'hFF, 13'h0008);
      rd_chk(epci_pkg::IDX_PC_FLAGS, 8'h01);
      check({30'h0, pc_irq}, 32'h1);
      wr(epci_pkg::IDX_PC_FLAGS, 8'h01);
      rd_chk(epci_pkg::IDX_PC_FLAGS, 8'h00);
      pins(8'hFF, 13'h0018);
      rd_chk(epci_pkg::IDX_PC_FLAGS, 8'h00);
      wr(epci_pkg::IDX_PC_MASK_HI, 8'h10);
      pins(8'hFF, 13'h1018);
      rd_chk(epci_pkg::IDX_PC_FLAGS, 8'h02);
      check({30'h0, pc_irq}, 32'h0);
      wr(epci_pkg::IDX_PC_CTRL, 8'h03);
      ack_en <= 1'b1;
      cyc(12);
      rd_chk(epci_pkg::IDX_PC_FLAGS, 8'h00);
      report_and_stop();
   end
endmodule : test_epci_top
`default_nettype wire
